// ### sdk_codec.sv
// Segment decode, key readback with debounce, and bus self-addressing
`timescale 1ns/1ns
`default_nettype none
`include "sdk_params.svh"

module sdk_codec #(
    parameter int DEBOUNCE_CYC = `SDK_DEBOUNCE_MS * `SDK_CLK_KHZ
) (
    input  wire logic        mclk,
    input  wire logic        rst_b,
    input  wire logic [7:0]  reg_addr,
    input  wire logic        wr_stb,
    input  wire logic [7:0]  wr_data,
    input  wire logic        rd_stb,
    output logic      [7:0]  rd_data,
    input  wire logic        scan_tick,
    input  wire logic [7:0]  key_group_a,
    input  wire logic [7:0]  key_group_b,
    output logic      [63:0] digit_segments,
    output logic      [6:0]  bus_addr,
    output logic             irq_o,
    output logic             irq_oe
);
    import sdk_pkg::*;

    localparam sdk_cnt_t DB_LAST = sdk_cnt_t'(DEBOUNCE_CYC - 1);

    sdk_state_s      st_r;
    sdk_state_s      st_nxt;
    logic [7:0][7:0] dec_seg;
    logic [7:0]      mask_a;
    logic [7:0]      scan_a;
    logic            user_addr;
    logic            key_read;

    genvar gi;
    generate
        for (gi = 0; gi < 8; gi++) begin : g_digit
            sdk_font_decoder u_font (
                .digit_byte (st_r.digit[gi]),
                .decode_en  (st_r.decode_sel[gi]), // R1
                .hex_font   (st_r.feature[`SDK_FEAT_HEX_BIT]), // R3
                .seg        (dec_seg[gi])
            );
        end
    endgenerate

    always_comb begin
        st_nxt    = st_r;
        user_addr = st_r.addr_src[`SDK_ADDR_USER_BIT]; // R12
        // Address nodes are not keys while self-addressing is on
        mask_a    = 8'hFF;
        if (user_addr) begin
            mask_a[`SDK_KEY_F_BIT] = 1'b0; // R8
            mask_a[`SDK_KEY_G_BIT] = 1'b0;
        end
        scan_a    = key_group_a & mask_a;
        key_read  = rd_stb && (reg_addr == `SDK_REG_KEY_A
                               || reg_addr == `SDK_REG_KEY_B);

        // Register writes
        if (wr_stb) begin
            if (reg_addr >= `SDK_DIGIT_BASE && reg_addr <= `SDK_DIGIT_LAST) begin
                st_nxt.digit[3'(reg_addr - `SDK_DIGIT_BASE)] = wr_data;
            end
            case (reg_addr)
                `SDK_REG_DECODE:   st_nxt.decode_sel = wr_data; // R1
                `SDK_REG_FEATURE:  st_nxt.feature    = wr_data;
                `SDK_REG_ADDR_SRC: st_nxt.addr_src   = wr_data; // R12
                default: ;
            endcase
        end

        // Register reads answer one cycle after the strobe
        if (rd_stb) begin
            st_nxt.rd_data = `SDK_UNMAPPED_DATA;
            if (reg_addr >= `SDK_DIGIT_BASE && reg_addr <= `SDK_DIGIT_LAST) begin
                st_nxt.rd_data = st_r.digit[3'(reg_addr - `SDK_DIGIT_BASE)];
            end
            case (reg_addr)
                `SDK_REG_DECODE:   st_nxt.rd_data = st_r.decode_sel;
                `SDK_REG_FEATURE:  st_nxt.rd_data = st_r.feature;
                `SDK_REG_ADDR_SRC: st_nxt.rd_data = st_r.addr_src;
                `SDK_REG_KEY_A:    st_nxt.rd_data = st_r.key_a; // R15
                `SDK_REG_KEY_B:    st_nxt.rd_data = st_r.key_b; // R15
                default: ;
            endcase
        end

        // Segment drive registered so the pins never glitch between digits
        st_nxt.seg = dec_seg;

        // Address nodes follow every scan with no debounce
        if (scan_tick) begin
            st_nxt.addr_nodes = {key_group_a[`SDK_KEY_F_BIT],
                                 key_group_a[`SDK_KEY_G_BIT]}; // R13 R11
        end
        // A write to the source register re-addresses every device at once
        if (user_addr) begin
            st_nxt.bus_addr = {5'h00, st_r.addr_nodes}; // R8 R10
        end else begin
            st_nxt.bus_addr = `SDK_FACTORY_ADDR; // R9
        end

        // Interrupt clear from the read; a commit below that changes the key data overrides it
        if (key_read) begin
            st_nxt.irq_act = 1'b0; // R18
        end

        // Debounce: any change in a scan outside the masked address nodes restarts the stability window
        case (st_r.db_st)
            SDK_DB_IDLE: begin
                if (scan_tick && (scan_a != st_r.samp_a
                                  || key_group_b != st_r.samp_b)) begin // R19
                    st_nxt.samp_a = scan_a;
                    st_nxt.samp_b = key_group_b;
                    st_nxt.db_cnt = '0;
                    st_nxt.db_st  = SDK_DB_SETTLE;
                end
            end
            SDK_DB_SETTLE: begin
                if (scan_tick && (scan_a != st_r.samp_a
                                  || key_group_b != st_r.samp_b)) begin
                    st_nxt.samp_a = scan_a;
                    st_nxt.samp_b = key_group_b;
                    st_nxt.db_cnt = '0;
                end else if (st_r.db_cnt >= DB_LAST) begin
                    st_nxt.key_a = st_r.samp_a; // R16
                    st_nxt.key_b = st_r.samp_b;
                    st_nxt.db_st = SDK_DB_IDLE;
                    if (st_r.samp_a != st_r.key_a || st_r.samp_b != st_r.key_b) begin
                        st_nxt.irq_act = 1'b1; // R17
                    end
                end else begin
                    st_nxt.db_cnt = st_r.db_cnt + 1'b1;
                end
            end
            default: begin
                st_nxt.db_st  = SDK_DB_IDLE;
                st_nxt.db_cnt = '0;
            end
        endcase

        // Address bits leaving key duty must not linger as stale key data
        st_nxt.key_a = st_nxt.key_a & mask_a; // R8
    end

    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            st_r       <= '0;
            st_r.db_st <= SDK_DB_IDLE;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign rd_data        = st_r.rd_data;
    assign digit_segments = st_r.seg;
    assign bus_addr       = st_r.bus_addr;
    // Open-drain: only ever pulls low, released otherwise
    assign irq_o          = 1'b0;
    assign irq_oe         = st_r.irq_act; // R17 R18

endmodule // sdk_codec

`default_nettype wire

// ### sdk_params.svh
// Constants for the segment decoder and key readback block
// Summary of operation
// R1: Decode select bit n governs digit n
// R2: Bit set decodes digit, clear bypasses decoder
// R3: Feature bit D2 picks code-B or hex font
// R4: Decoder uses low nibble, ignores D6:D4
// R5: D7 drives decimal point in decoded mode
// R6: Undecoded byte drives point and A to G
// R7: Fixed nibble to segment tables per font
// R8: Group A G and F nodes feed address
// R9: Respond to address zero until self-addressed
// R10: One command re-addresses all devices together
// R11: Shorted node gives 1, open gives 0
// R12: Address source bit D0 factory or user
// R13: Address bits bypass key debounce
// R14: Address nodes must be fixed wiring
// R15: Key registers at 0x1C and 0x1D
// R16: Key registers update after 20ms stable
// R17: Key register change drives interrupt low
// R18: Key register read releases interrupt line
// R19: Key data refreshed every scan cycle
// R20: Host reads keys promptly after interrupt
`ifndef SDK_PARAMS_SVH
`define SDK_PARAMS_SVH

`define SDK_DIGIT_BASE    8'h01
`define SDK_DIGIT_LAST    8'h08
`define SDK_REG_DECODE    8'h09
`define SDK_REG_FEATURE   8'h0E
`define SDK_REG_KEY_A     8'h1C
`define SDK_REG_KEY_B     8'h1D
`define SDK_REG_ADDR_SRC  8'h2D

`define SDK_FEAT_HEX_BIT  2
`define SDK_ADDR_USER_BIT 0
`define SDK_KEY_F_BIT     1
`define SDK_KEY_G_BIT     0

`define SDK_RST_BYTE      8'h00
`define SDK_FACTORY_ADDR  7'h00
`define SDK_UNMAPPED_DATA 8'h00

`define SDK_DEBOUNCE_MS   20
`define SDK_CLK_KHZ       100000
`define SDK_DB_CNT_W      21

`endif

// ### sdk_pkg.sv
// Types shared by the segment decoder and key readback block
`include "sdk_params.svh"

package sdk_pkg;

    typedef enum logic [1:0] {
        SDK_DB_IDLE   = 2'b01,
        SDK_DB_SETTLE = 2'b10
    } sdk_db_e;

    typedef logic [`SDK_DB_CNT_W-1:0] sdk_cnt_t;

    typedef struct packed {
        logic [7:0][7:0] digit;
        logic [7:0][7:0] seg;
        logic [7:0]      decode_sel;
        logic [7:0]      feature;
        logic [7:0]      addr_src;
        logic [7:0]      key_a;
        logic [7:0]      key_b;
        logic [7:0]      samp_a;
        logic [7:0]      samp_b;
        logic [1:0]      addr_nodes;
        logic [6:0]      bus_addr;
        sdk_cnt_t        db_cnt;
        sdk_db_e         db_st;
        logic            irq_act;
        logic [7:0]      rd_data;
    } sdk_state_s;

endpackage

// ### sdk_font_decoder.sv
// Per-digit font decoder and decoder bypass
`timescale 1ns/1ns
`default_nettype none

module sdk_font_decoder (
    input  wire logic [7:0] digit_byte,
    input  wire logic       decode_en,
    input  wire logic       hex_font,
    output logic      [7:0] seg
);

    logic [6:0] glyph;

    // Segment order is A..G in bits 6..0
    always_comb begin
        glyph = 7'h00;
        case (digit_byte[3:0]) // R4
            4'h0: glyph = 7'h7E; // R7
            4'h1: glyph = 7'h30;
            4'h2: glyph = 7'h6D;
            4'h3: glyph = 7'h79;
            4'h4: glyph = 7'h33;
            4'h5: glyph = 7'h5B;
            4'h6: glyph = 7'h5F;
            4'h7: glyph = 7'h70;
            4'h8: glyph = 7'h7F;
            4'h9: glyph = 7'h7B;
            4'hA: glyph = hex_font ? 7'h77 : 7'h01; // R3
            4'hB: glyph = hex_font ? 7'h1F : 7'h4F;
            4'hC: glyph = hex_font ? 7'h4E : 7'h37;
            4'hD: glyph = hex_font ? 7'h3D : 7'h0E;
            4'hE: glyph = hex_font ? 7'h4F : 7'h67;
            4'hF: glyph = hex_font ? 7'h47 : 7'h00;
            default: glyph = 7'h00;
        endcase
        if (decode_en) begin // R2
            seg = {digit_byte[7], glyph}; // R5
        end else begin
            seg = digit_byte; // R6
        end
    end

endmodule // sdk_font_decoder

`default_nettype wire

// ### sdk_codec_chk.sv
// Port assertions for the segment decoder and key readback block
`timescale 1ns/1ns
`default_nettype none
module sdk_codec_chk #(
    parameter int DEBOUNCE_CYC = 2000000
) (
    input wire logic        mclk,
    input wire logic        rst_b,
    input wire logic [7:0]  reg_addr,
    input wire logic        wr_stb,
    input wire logic [7:0]  wr_data,
    input wire logic        rd_stb,
    input wire logic [7:0]  rd_data,
    input wire logic        scan_tick,
    input wire logic [7:0]  key_group_a,
    input wire logic [7:0]  key_group_b,
    input wire logic [63:0] digit_segments,
    input wire logic [6:0]  bus_addr,
    input wire logic        irq_o,
    input wire logic        irq_oe
);
    logic [7:0] dec_r;
    wire logic key_rd = rd_stb && (reg_addr == 8'h1C || reg_addr == 8'h1D);
    always_ff @(posedge mclk)
        dec_r <= !rst_b ? 8'h00 : (wr_stb && reg_addr == 8'h09) ? wr_data : dec_r;
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_b);
    // A following write reaches the pins a cycle after the one being checked
    sequence s_dig0_wr;
        wr_stb && reg_addr == 8'h01 ##1 !wr_stb;
    endsequence
    AST_IRQ_DRV: assert property (irq_o == 1'b0)
        else $error("irq data not low");
    AST_IRQ_HOLD: assert property (irq_oe && !key_rd |=> irq_oe)
        else $error("irq released without key read");
    AST_ADDR_HI: assert property (bus_addr[6:2] == 5'h00)
        else $error("upper address bits set");
    AST_ADDR_FACT: assert property (wr_stb && reg_addr == 8'h2D && !wr_data[0] ##1 !wr_stb
        |=> bus_addr == 7'h00)
        else $error("factory address not restored");
    AST_RD_UNMAP: assert property (rd_stb && reg_addr == 8'h20 |=> rd_data == 8'h00)
        else $error("unmapped read not zero");
    AST_RD_HOLD: assert property (!rd_stb |=> $stable(rd_data))
        else $error("read data moved");
    AST_SEG_DP: assert property (s_dig0_wr |=> digit_segments[7] == $past(wr_data[7], 2))
        else $error("decimal point wrong");
    AST_SEG_RAW: assert property (s_dig0_wr ##0 !dec_r[0]
        |=> digit_segments[7:0] == $past(wr_data, 2))
        else $error("bypassed digit wrong");
endmodule // sdk_codec_chk
bind sdk_codec sdk_codec_chk #(.DEBOUNCE_CYC(DEBOUNCE_CYC)) sdk_codec_chk_i (.mclk(mclk),
    .rst_b(rst_b), .reg_addr(reg_addr), .wr_stb(wr_stb), .wr_data(wr_data), .rd_stb(rd_stb),
    .rd_data(rd_data), .scan_tick(scan_tick), .key_group_a(key_group_a),
    .key_group_b(key_group_b), .digit_segments(digit_segments), .bus_addr(bus_addr),
    .irq_o(irq_o), .irq_oe(irq_oe));
`default_nettype wire

// ### sdk_host.sv
// Host model driving the register port
`timescale 1ns/1ns
`default_nettype none
module sdk_host (
    input  wire logic       mclk,
    output var  logic [7:0] reg_addr,
    output var  logic       wr_stb,
    output var  logic [7:0] wr_data,
    output var  logic       rd_stb,
    input  wire logic [7:0] rd_data
);
    initial {reg_addr, wr_stb, wr_data, rd_stb} = '0;
    task automatic wr(input logic [7:0] a, input logic [7:0] dv);
        @(posedge mclk);
        reg_addr <= a;
        wr_data  <= dv;
        wr_stb   <= 1'b1;
        @(posedge mclk);
        wr_stb   <= 1'b0;
        // Stale data must not look valid
        wr_data  <= ~dv;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] dv);
        @(posedge mclk);
        reg_addr <= a;
        rd_stb   <= 1'b1;
        @(posedge mclk);
        rd_stb   <= 1'b0;
        // Read data stands from the strobe edge until the next strobe
        @(posedge mclk);
        dv = rd_data;
    endtask
endmodule // sdk_host
`default_nettype wire

// ### testbench.sv
// Self-checking bench for the segment decoder and key readback block
`timescale 1ns/1ns
`default_nettype none
`include "sdk_params.svh"
module testbench;
    import sdk_pkg::*;
    localparam int DB = 20;
    logic        mclk = 1'b0, rst_b = 1'b0, scan_tick = 1'b0, wr_stb, rd_stb, irq_o, irq_oe;
    logic [7:0]  key_a = 8'h00, key_b = 8'h00, reg_addr, wr_data, rd_data, d, ka, kb, dec, hx;
    logic [63:0] segs, ex;
    logic [6:0]  bus_addr;
    logic [6:0]  fb [16] = '{7'h7E, 7'h30, 7'h6D, 7'h79, 7'h33, 7'h5B, 7'h5F, 7'h70, 7'h7F,
        7'h7B, 7'h01, 7'h4F, 7'h37, 7'h0E, 7'h67, 7'h00};
    logic [6:0]  fh [6] = '{7'h77, 7'h1F, 7'h4E, 7'h3D, 7'h4F, 7'h47};
    int          n_mismatch = 0, check_count = 0, i, j;
    always #5 mclk = ~mclk;
    always @(posedge mclk) scan_tick <= ~scan_tick;
    sdk_host sdk_host_i (.mclk(mclk), .reg_addr(reg_addr), .wr_stb(wr_stb), .wr_data(wr_data),
        .rd_stb(rd_stb), .rd_data(rd_data));
    sdk_codec #(.DEBOUNCE_CYC(DB)) sdk_codec_i (.mclk(mclk), .rst_b(rst_b), .reg_addr(reg_addr),
        .wr_stb(wr_stb), .wr_data(wr_data), .rd_stb(rd_stb), .rd_data(rd_data),
        .scan_tick(scan_tick), .key_group_a(key_a), .key_group_b(key_b),
        .digit_segments(segs), .bus_addr(bus_addr), .irq_o(irq_o), .irq_oe(irq_oe));
    task automatic chk(input logic [63:0] g, input logic [63:0] e);
        check_count++;
        if (g !== e) begin
            n_mismatch++;
            $display("wrong value at %0t: got %h expected %h", $time, g, e);
        end
    endtask
    task automatic final_report();
        $display("checks %0d mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    initial begin
        void'($urandom(32'h732CFFC1));
        repeat (6) @(posedge mclk);
        rst_b <= 1'b1;
        sdk_host_i.wr(`SDK_REG_KEY_A, 8'hFF);
        sdk_host_i.rd(`SDK_REG_KEY_A, d);
        chk(d, 8'h00);
        // Early rounds decode all digits so every nibble meets both fonts
        for (i = 0; i < 24; i++) begin
            dec = (i < 16) ? 8'hFF : 8'($urandom);
            hx = {5'($urandom), i[1], 2'($urandom)};
            sdk_host_i.wr(`SDK_REG_DECODE, dec);
            sdk_host_i.wr(`SDK_REG_FEATURE, hx);
            for (j = 0; j < 8; j++) begin
                d = {4'($urandom), 4'(i * 8 + j)};
                sdk_host_i.wr(8'(j + 1), d);
                ex[8*j+:8] = !dec[j] ? d : {d[7], (hx[2] && d[3:0] > 4'h9) ?
                    fh[d[3:0] - 4'hA] : fb[d[3:0]]};
            end
            repeat (2) @(posedge mclk);
            chk(segs, ex);
        end
        sdk_host_i.rd(`SDK_REG_FEATURE, d);
        chk(d, hx);
        sdk_host_i.rd(8'h20, d);
        chk(d, `SDK_UNMAPPED_DATA);
        ka = 8'($urandom) | 8'h01;
        kb = 8'($urandom);
        @(posedge mclk);
        key_a <= ka;
        key_b <= kb;
        repeat (6) @(posedge mclk);
        key_a <= ka ^ 8'h04;
        repeat (10) @(posedge mclk);
        key_a <= ka;
        j = 0;
        while (irq_oe !== 1'b1 && j < 100) begin
            @(posedge mclk);
            j++;
        end
        chk(j >= DB && j < 100, 1'b1);
        if (j == 100) final_report();
        chk(irq_o, 1'b0);
        sdk_host_i.rd(`SDK_REG_KEY_A, d);
        chk(irq_oe, 1'b0);
        chk(d, ka);
        sdk_host_i.rd(`SDK_REG_KEY_B, d);
        chk(d, kb);
        key_a <= 8'h02;
        sdk_host_i.wr(`SDK_REG_ADDR_SRC, 8'h01);
        repeat (4) @(posedge mclk);
        chk(bus_addr, 7'h02);
        // Address nodes must never show up as pressed keys
        repeat (DB + 10) @(posedge mclk);
        sdk_host_i.rd(`SDK_REG_KEY_A, d);
        chk(d, 8'h00);
        sdk_host_i.wr(`SDK_REG_ADDR_SRC, 8'hFE);
        repeat (2) @(posedge mclk);
        chk(bus_addr, 7'h00);
        final_report();
    end
endmodule // testbench
`default_nettype wire
